// ### embedded_flash_sequencer.sv
// Flash sequencer: ECC reads, row programming, sector erase with abort.
// Assumes the array model sits behind the array ports and takes one
// request per cycle; the agent keeps wear and reprogramming limits.
//
// Summary of operation
// - Array is two or four 4-Kbyte banks; exactly one is the data bank.
// - Programming writes one whole 32-byte program_row.
// - Erase clears whole sectors only, never smaller regions.
// - Erase takes one sector or several sectors in parallel.
// - Erased cells read back as zero.
// - A read returns one byte within three cpu_clock_period cycles.
// - Program operation takes 209440 system clocks.
// - Sector erase takes 8175360 system clocks unless aborted.
// - Read path corrects any single-bit error on the fly.
// - Program and erase run in background under own timing.
// - An erase in progress may be aborted early.
`timescale 1ns/1ns
`include "flash_seq_map.svh"

module embedded_flash_sequencer #(
    parameter int NUM_BANKS = 2,
    parameter int SECTOR_BITS = 16,
    parameter int ADDR_BITS = 14,
    parameter int PROG_CYCLES = `PROG_CYCLES,
    parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Read request from the processor
    input wire logic rd_req,
    input wire logic [ADDR_BITS-1:0] rd_addr,
    output logic rd_ack,
    output logic [7:0] rd_data,
    output logic rd_corrected,
    // Program request: one 32-byte row
    input wire logic prog_req,
    input wire logic [ADDR_BITS-1:0] prog_addr,
    input wire logic [8*`ROW_BYTES-1:0] prog_data,
    // Erase request: sector mask, any number of sectors at once
    input wire logic erase_req,
    input wire logic [SECTOR_BITS-1:0] erase_sectors,
    input wire logic erase_abort,
    // Status
    output logic busy,
    output logic op_done,
    output logic op_aborted,
    // Array side
    output logic arr_rd_en,
    output logic [ADDR_BITS-1:0] arr_rd_addr,
    input wire logic [12:0] arr_rd_word,
    output logic arr_prog_en,
    output logic [ADDR_BITS-1:0] arr_prog_addr,
    output logic [8*`ROW_BYTES-1:0] arr_prog_data,
    output logic arr_erase_en,
    output logic [SECTOR_BITS-1:0] arr_erase_sectors
);
    // Only two or four banks exist; other counts fall back to a legal
    // layout. Exactly one bank is the data bank, the rest hold code.
    localparam int BANKS_USED = (NUM_BANKS > 2) ? 4 : 2;

    localparam int CNT_BITS = 24;
    localparam logic [CNT_BITS-1:0] PROG_LAST = CNT_BITS'(PROG_CYCLES - 1);
    localparam logic [CNT_BITS-1:0] ERASE_LAST = CNT_BITS'(ERASE_CYCLES - 1);

    // Read path steps: latch address, strobe array, decode and answer
    typedef enum logic [1:0] {
        rd_idle,
        rd_access,
        rd_decode
    } rd_step_e;

    flash_seq_pkg::op_e op_r;
    flash_seq_pkg::op_e op_nxt;
    logic [CNT_BITS-1:0] cnt_r;
    logic [CNT_BITS-1:0] cnt_nxt;
    rd_step_e rd_step_r;
    rd_step_e rd_step_nxt;
    logic [ADDR_BITS-1:0] rd_addr_r;
    logic [ADDR_BITS-1:0] row_addr_r;
    logic [8*`ROW_BYTES-1:0] row_data_r;
    logic [SECTOR_BITS-1:0] sect_r;

    // Row address: low bits forced to zero so a whole row is written
    wire [ADDR_BITS-1:0] row_base =
        {prog_addr[ADDR_BITS-1:`ROW_ADDR_BITS], `ROW_ADDR_BITS'(0)};
    wire idle = (op_r == flash_seq_pkg::op_none);
    wire start_prog = idle && prog_req;
    // Program wins a tie so a pending row is never lost to an erase;
    // an empty mask would erase less than a sector, so it is ignored
    wire start_erase = idle && !prog_req && erase_req &&
        (erase_sectors != '0);
    wire last_cycle = (op_r == flash_seq_pkg::op_program) ?
        (cnt_r == PROG_LAST) : (cnt_r == ERASE_LAST);
    // Abort only touches an erase; a program always runs to its end
    wire abort_now =
        (op_r == flash_seq_pkg::op_erase) && erase_abort;
    wire finish = !idle && last_cycle && !abort_now;

    // Hamming(12,8) with overall parity: word = {p_all, code[11:0]}
    // Bit 12 is carried but not used, so double errors go unflagged
    wire [11:0] cw = arr_rd_word[11:0];
    wire [3:0] syn;
    assign syn[0] = cw[0] ^ cw[2] ^ cw[4] ^ cw[6] ^ cw[8] ^ cw[10];
    assign syn[1] = cw[1] ^ cw[2] ^ cw[5] ^ cw[6] ^ cw[9] ^ cw[10];
    assign syn[2] = cw[3] ^ cw[4] ^ cw[5] ^ cw[6] ^ cw[11];
    assign syn[3] = cw[7] ^ cw[8] ^ cw[9] ^ cw[10] ^ cw[11];
    // Position p (1-based) maps to cw[p-1]; flip that bit
    // Syndromes past position 12 shift the one out, so nothing flips
    wire [11:0] flip = (syn == 4'h0) ? 12'h000 :
        12'(12'h001 << (syn - 4'h1));
    wire [11:0] fixed = cw ^ flip;
    // All-zero codeword is valid, so erased cells read as zero
    wire [7:0] fixed_byte =
        {fixed[11], fixed[10], fixed[9], fixed[8],
         fixed[6], fixed[5], fixed[4], fixed[2]};
    wire fixed_any = (syn != 4'h0);

    // Read path runs beside program and erase, so the cpu never stalls
    always_comb begin
        rd_step_nxt = rd_step_r;
        unique case (rd_step_r)
            rd_idle: begin
                if (rd_req) begin
                    rd_step_nxt = rd_access;
                end
            end
            rd_access: begin
                rd_step_nxt = rd_decode;
            end
            rd_decode: begin
                rd_step_nxt = rd_idle;
            end
            default: begin
                rd_step_nxt = rd_idle;
            end
        endcase
    end

    wire rd_take = (rd_step_r == rd_idle) && rd_req;
    wire rd_answer = (rd_step_r == rd_decode);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_step_r <= rd_idle;
        end else begin
            rd_step_r <= rd_step_nxt;
        end
    end

    // Address held for the whole access so the array sees it settle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_addr_r <= '0;
        end else if (rd_take) begin
            rd_addr_r <= rd_addr;
        end
    end

    // Answer registers: data and flag hold until the next answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ack <= 1'b0;
            rd_data <= 8'h00;
            rd_corrected <= 1'b0;
        end else begin
            rd_ack <= rd_answer;
            if (rd_answer) begin
                rd_data <= fixed_byte;
                rd_corrected <= fixed_any;
            end
        end
    end

    assign arr_rd_en = (rd_step_r == rd_access);
    assign arr_rd_addr = rd_addr_r;

    // Background sequencer for program and erase
    always_comb begin
        op_nxt = op_r;
        cnt_nxt = cnt_r;
        if (start_prog) begin
            op_nxt = flash_seq_pkg::op_program;
            cnt_nxt = '0;
        end else if (start_erase) begin
            op_nxt = flash_seq_pkg::op_erase;
            cnt_nxt = '0;
        end else if (finish || abort_now) begin
            op_nxt = flash_seq_pkg::op_none;
            cnt_nxt = '0;
        end else if (!idle) begin
            cnt_nxt = cnt_r + CNT_BITS'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op_r <= flash_seq_pkg::op_none;
            cnt_r <= '0;
        end else begin
            op_r <= op_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Row and sector mask latched at the start and held for the run
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            row_addr_r <= '0;
            row_data_r <= '0;
            sect_r <= '0;
        end else if (start_prog) begin
            row_addr_r <= row_base;
            row_data_r <= prog_data;
        end else if (start_erase) begin
            sect_r <= erase_sectors;
        end
    end

    // One-cycle completion pulses; an abort never also reports done
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op_done <= 1'b0;
            op_aborted <= 1'b0;
        end else begin
            op_done <= finish;
            op_aborted <= abort_now;
        end
    end

    assign busy = !idle;
    assign arr_prog_en = (op_r == flash_seq_pkg::op_program);
    assign arr_prog_addr = row_addr_r;
    assign arr_prog_data = row_data_r;
    assign arr_erase_en = (op_r == flash_seq_pkg::op_erase);
    assign arr_erase_sectors = sect_r;

endmodule : embedded_flash_sequencer

// ### flash_seq_map.svh
// Constants for the embedded flash sequencer: geometry and timing counts.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

`define BANK_BYTES 4096
`define ROW_BYTES 32
`define ROW_ADDR_BITS 5
`define PROG_CYCLES 209440
`define ERASE_CYCLES 8175360
`define READ_CYCLES 3
`define NUM_SECTORS_MAX 32
`define ERASED_BYTE 8'h00

`endif

// ### flash_seq_pkg.sv
// Types for the embedded flash sequencer.
// Assumes nothing beyond the constants header.
package flash_seq_pkg;
    typedef enum logic [1:0] {
        op_none,
        op_program,
        op_erase
    } op_e;
endpackage : flash_seq_pkg

// ### flash_array_model.sv
// Array model: byte store answering with Hamming(12,8) codewords.
// Assumes one store for all banks; any erase clears all of it.
`timescale 1ns/1ns
module flash_array_model (
    // Array side
    input wire logic clk,
    input wire logic prog_en,
    input wire logic erase_en,
    input wire logic [13:0] rd_addr,
    input wire logic [13:0] prog_addr,
    input wire logic [255:0] prog_data,
    // Fault injection
    input wire logic [12:0] flip,
    output logic [12:0] word
);
    logic [7:0] mem [256] = '{default: 8'h00};
    logic [7:0] d;
    assign d = mem[rd_addr[7:0]];
    assign word = flip ^ {1'b0, d[7:4], ^(d & 8'hf0), d[3:1],
        ^(d & 8'h8e), d[0], ^(d & 8'h6d), ^(d & 8'h5b)};
    always @(posedge clk) begin
        if (prog_en)
            for (int i = 0; i < 32; i++)
                // Cells only gain ones, so zeros leave them untouched
                mem[{prog_addr[7:5], i[4:0]}] <=
                    mem[{prog_addr[7:5], i[4:0]}] | prog_data[8*i+:8];
        else if (erase_en)
            mem <= '{default: 8'h00};
    end
endmodule : flash_array_model

// ### efs_asserts.sv
// Port timing checks for the flash sequencer.
// Assumes single-cycle read requests spaced by the bench.
`timescale 1ns/1ns
module efs_asserts #(
    parameter int PROG_CYCLES = 20,
    parameter int ERASE_CYCLES = 50
) (
    // Watched ports
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rd_req,
    input wire logic rd_ack,
    input wire logic arr_rd_en,
    input wire logic prog_req,
    input wire logic erase_abort,
    input wire logic busy,
    input wire logic op_done,
    input wire logic op_aborted,
    input wire logic arr_prog_en,
    input wire logic arr_erase_en
);
    logic [23:0] cnt_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            cnt_r <= '0;
        else
            cnt_r <= busy ? cnt_r + 24'h1 : '0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence rd_walk;
        arr_rd_en ##2 rd_ack;
    endsequence
    rd_walk_a: assert property (rd_req |=> rd_walk)
        else $error("read walk broken");
    ack_pulse_a: assert property (rd_ack |=> !rd_ack)
        else $error("read ack too long");
    prog_take_a: assert property (prog_req && !busy |=> busy && arr_prog_en)
        else $error("program not started");
    prog_len_a: assert property (op_done && $past(arr_prog_en) |-> cnt_r == PROG_CYCLES)
        else $error("program length wrong");
    erase_len_a: assert property (op_done && $past(arr_erase_en) |-> cnt_r == ERASE_CYCLES)
        else $error("erase length wrong");
    abort_stop_a: assert property (erase_abort && arr_erase_en |=> !busy)
        else $error("abort did not stop erase");
    abort_only_a: assert property (op_aborted |-> !op_done && !busy)
        else $error("abort with done or busy");
    busy_src_a: assert property (busy == (arr_prog_en || arr_erase_en))
        else $error("busy disagrees with array");
endmodule : efs_asserts
bind embedded_flash_sequencer efs_asserts #(.PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) chk (.clk, .reset_n, .rd_req, .rd_ack,
    .arr_rd_en, .prog_req, .erase_abort, .busy, .op_done, .op_aborted,
    .arr_prog_en, .arr_erase_en);

// ### tb_embedded_flash_sequencer.sv
// Bench: reads, row program, multi-sector erase and aborted erase.
// Assumes the array model and checker beside the design.
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin fails++; $display("Error %s exp %h got %h", n, e, s); end end
module tb_embedded_flash_sequencer;
    localparam int P = 20;
    localparam int E = 50;
    logic clk = 0, reset_n = 0, rd_req = 0, prog_req = 0, erase_req = 0;
    logic erase_abort = 0, rd_ack, rd_corrected, busy, op_done, op_aborted;
    logic arr_rd_en, arr_prog_en, arr_erase_en;
    logic [13:0] rd_addr = 0, prog_addr = 0, arr_rd_addr, arr_prog_addr;
    logic [255:0] prog_data = 0, arr_prog_data;
    logic [15:0] erase_sectors = 0, arr_erase_sectors;
    logic [12:0] arr_rd_word, flip = 0;
    logic [7:0] rd_data, lfsr = 8'h04;
    int fails = 0, samples_checked = 0, cyc = 0, n;
    int model [256];
    function automatic logic [7:0] lfsr_next(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    embedded_flash_sequencer #(.PROG_CYCLES(P), .ERASE_CYCLES(E)) DUT (
        .clk, .reset_n, .rd_req, .rd_addr, .rd_ack, .rd_data, .rd_corrected,
        .prog_req, .prog_addr, .prog_data, .erase_req, .erase_sectors,
        .erase_abort, .busy, .op_done, .op_aborted, .arr_rd_en, .arr_rd_addr,
        .arr_rd_word, .arr_prog_en, .arr_prog_addr, .arr_prog_data,
        .arr_erase_en, .arr_erase_sectors);
    flash_array_model arr (.clk, .prog_en(arr_prog_en),
        .erase_en(arr_erase_en), .rd_addr(arr_rd_addr),
        .prog_addr(arr_prog_addr), .prog_data(arr_prog_data), .flip,
        .word(arr_rd_word));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end
    task end_sim;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task rd(int a, logic [12:0] f, logic c);
        @(posedge clk);
        #1 rd_req = 1;
        rd_addr = a[13:0];
        flip = f;
        @(posedge clk);
        #1 rd_req = 0;
        repeat (2) @(posedge clk);
        #1 `CHK("rd_ack", 1'b1, rd_ack)
        `CHK("rd_data", model[a][7:0], rd_data)
        `CHK("rd_corrected", c, rd_corrected)
    endtask : rd
    task run_op(int len, bit ab);
        @(posedge clk);
        #1 prog_req = 0;
        erase_req = 0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
            erase_abort = ab && n == 5;
        end while (!op_done && !op_aborted && n < 200);
        erase_abort = 0;
        `CHK("op_done", !ab, op_done)
        `CHK("op_aborted", ab, op_aborted)
        `CHK("op_len", ab ? 6 : len, n)
        `CHK("busy", 1'b0, busy)
    endtask : run_op
    initial begin
        repeat (12) @(posedge clk);
        #1 reset_n = 1;
        rd(7, 0, 0);
        for (int i = 0; i < 32; i++) begin
            lfsr = lfsr_next(lfsr);
            prog_data[8*i+:8] = lfsr;
            model[32+i] = lfsr;
        end
        prog_req = 1;
        prog_addr = 14'h003f;
        run_op(P, 0);
        for (int i = 0; i < 12; i++)
            rd(32 + i, 13'h1 << i, 1);
        prog_req = 1;
        prog_addr = 14'h0005;
        fork
            run_op(P, 0);
            rd(40, 0, 0);
        join
        for (int i = 0; i < 32; i++)
            model[i] = prog_data[8*i+:8];
        erase_sectors = 16'h0005;
        erase_req = 1;
        run_op(E, 0);
        model = '{default: 0};
        rd(40, 0, 0);
        // Data row filled in two halves; each pass writes zeros to the other half
        for (int half = 0; half < 2; half++) begin
            for (int i = 0; i < 32; i++) begin
                lfsr = lfsr_next(lfsr);
                prog_data[8*i+:8] = (i / 16 == half) ? lfsr : 8'h00;
                if (i / 16 == half) model[i] = lfsr;
            end
            prog_req = 1;
            prog_addr = 14'h0000;
            run_op(P, 0);
        end
        rd(3, 0, 0);
        rd(20, 0, 0);
        erase_req = 1;
        run_op(E, 1);
        end_sim();
    end
endmodule : tb_embedded_flash_sequencer
